// File: nis_edge.sv
// Rising-edge detector on already synchronised levels
`timescale 1ns/100ps
module nis_edge #(
  parameter int width = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [width-1:0] level,
  output logic [width-1:0] rise
);
  logic [width-1:0] last_reg;
  always_ff @(posedge clk)
  begin
    if (reset)
      last_reg <= '0;
    else if (clk_en)
      last_reg <= level;
  end
  assign rise = level & ~last_reg;
endmodule

// File: nis_event_model.sv
// Event source model for the MAC, PHY and bus side of the unit
`timescale 1ns/100ps
module nis_event_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] ev,
  output logic system_error_event,
  output logic cable_length_change_event,
  output logic rx_status_fifo_overflow_event,
  output logic rx_read_pointer_write,
  output logic rx_buffer_empty,
  output logic link_status,
  output logic rx_ring_overflow_event,
  output logic tx_abort_event,
  output logic tx_done_event,
  output logic rx_packet_end,
  output logic rx_packet_good,
  output logic rx_crc_fault,
  output logic frame_alignment_fault
);
  logic [15:0] ev_reg = 16'h0000;
  logic [2:0] cnt_reg = 3'h0;
  logic link_reg = 1'h0;
  logic hold;
  logic first;
  // Async sources stay up four cycles so the synchroniser sees them
  always @(posedge clk)
  begin
    if (go) ev_reg <= ev;
    cnt_reg <= go ? 3'h4 : cnt_reg - 3'(cnt_reg != 3'h0);
    if (go && ev[5] && !ev[8]) link_reg <= !link_reg;
  end
  assign hold = cnt_reg != 3'h0;
  assign first = cnt_reg == 3'h4;
  assign system_error_event = hold && ev_reg[15];
  assign cable_length_change_event = hold && ev_reg[13];
  assign rx_status_fifo_overflow_event = hold && ev_reg[6];
  assign link_status = link_reg;
  assign rx_read_pointer_write = first && ev_reg[5] && ev_reg[8];
  assign rx_buffer_empty = ev_reg[8];
  assign rx_ring_overflow_event = first && ev_reg[4];
  assign tx_abort_event = first && ev_reg[3];
  assign tx_done_event = first && ev_reg[2];
  assign rx_packet_end = first && (ev_reg[1] || ev_reg[0]);
  assign rx_packet_good = first && ev_reg[0] && !ev_reg[1];
  // bit 7 picks alignment over CRC
  assign rx_crc_fault = first && ev_reg[1] && !ev_reg[7];
  assign frame_alignment_fault = first && ev_reg[1] && ev_reg[7];
endmodule

// File: nis_pkg.sv
// Shared constants for the interrupt status unit
package nis_pkg;
  // Status and mask offsets are word indices; bus address is four times
  localparam logic [7:0] status_offset = 8'h3e;
  localparam logic [7:0] mask_offset = 8'h3c;
  localparam logic [7:0] timer_offset = 8'h48;
  localparam logic [7:0] compare_offset = 8'h4c;
  localparam logic [7:0] control_offset = 8'h50;
  localparam logic [7:0] state_offset = 8'h54;
  localparam logic [15:0] status_reset = 16'h0000;
  localparam logic [15:0] mask_reset = 16'h0000;
  localparam logic [15:0] event_bits = 16'he07f;
  localparam logic [31:0] timer_reset = 32'h00000000;
  localparam logic [31:0] compare_reset = 32'h00000000;
  localparam logic [15:0] threshold_reset = 16'h0000;
  localparam int bit_system_error_event = 15;
  localparam int bit_timeout = 14;
  localparam int bit_cable_length_change_event = 13;
  localparam int bit_rx_status_fifo_overflow_event = 6;
  localparam int bit_pun = 5;
  localparam int bit_rx_ring_overflow_event = 4;
  localparam int bit_ter = 3;
  localparam int bit_tok = 2;
  localparam int bit_rer = 1;
  localparam int bit_rok = 0;
  localparam int ctl_early = 0;
  localparam int ctl_rx_enable = 1;
  localparam logic [4:0] runt_limit = 5'h10;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// File: nis_sync.sv
// Two-stage synchroniser for a group of level inputs
`timescale 1ns/100ps
module nis_sync #(
  parameter int width = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] stage_reg;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stage_reg <= '0;
      sync_out <= '0;
    end
    else if (clk_en)
    begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end
endmodule

// File: nis_unit.sv
// Interrupt status unit with AXI4-Lite register access
// How it works
// - A 16-bit status register names the events behind the interrupt pin.
// - A status bit drives the interrupt only when its mask bit is set.
// - Status bits latch every event regardless of the mask.
// - Reading the status register clears all pending bits.
// - Writes to the status register change nothing.
// - Bit 15 latches a bus system error.
// - Bit 14 latches when the free-running timer equals the compare value.
// - Bit 13 latches a cable length change while the receiver is enabled.
// - Bit 6 latches a receive status FIFO overflow.
// - Bit 5 latches read pointer write on empty buffer or link change.
// - Bit 4 latches receive ring exhaustion.
// - Bit 3 latches a transmit abort after retries run out.
// - Bit 2 latches a successful transmission.
// - Bit 1 latches a CRC or alignment fault on a received packet.
// - Collided frames under 16 bytes do not count as CRC faults.
// - Normal mode: bit 0 latches on good packet completion.
// - Early mode: bit 0 latches when byte count passes the threshold.
// - Bits 12 to 7 stay zero.
// - Reset clears every mask bit.
// - Mask bit one enables, zero disables, the same status bit.
`timescale 1ns/100ps
module nis_unit (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic system_error_event,
  input wire logic cable_length_change_event,
  input wire logic rx_status_fifo_overflow_event,
  input wire logic rx_read_pointer_write,
  input wire logic rx_buffer_empty,
  input wire logic link_status,
  input wire logic rx_ring_overflow_event,
  input wire logic tx_abort_event,
  input wire logic tx_done_event,
  input wire logic rx_packet_end,
  input wire logic rx_packet_good,
  input wire logic rx_crc_fault,
  input wire logic frame_alignment_fault,
  input wire logic rx_collided,
  input wire logic [10:0] rx_frame_length,
  input wire logic [15:0] rx_byte_count,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic interrupt_out
);
  // Pin-level event inputs from other clocks
  logic [3:0] pin_raw;
  logic [3:0] pin_sync;
  logic [3:0] pin_rise;
  logic link_sync;
  logic link_last_reg;
  logic [15:0] interrupt_event_status_reg;
  logic [15:0] interrupt_event_status_next;
  logic [15:0] interrupt_enable_mask_reg;
  logic [31:0] free_running_timer_count_reg;
  logic [31:0] timer_compare_value_reg;
  logic [15:0] early_threshold_reg;
  logic [1:0] control_reg;
  logic [15:0] event_now;
  logic [15:0] write_mask;
  logic crc_counts;
  logic early_crossed_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  logic do_read;
  logic [31:0] read_word;
  logic read_ok;

  assign pin_raw = {system_error_event, cable_length_change_event,
                    rx_status_fifo_overflow_event, link_status};

  nis_sync #(.width(4)) pin_sync_u (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(pin_raw),
    .sync_out(pin_sync)
  );

  nis_edge #(.width(4)) pin_edge_u (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .level(pin_sync),
    .rise(pin_rise)
  );

  assign link_sync = pin_sync[0];
  always_ff @(posedge clk)
  begin
    if (reset)
      link_last_reg <= 1'b0;
    else if (clk_en)
      link_last_reg <= link_sync;
  end

  // Free-running timer wraps silently
  always_ff @(posedge clk)
  begin
    if (reset)
      free_running_timer_count_reg <= nis_pkg::timer_reset;
    else if (clk_en)
      free_running_timer_count_reg <= free_running_timer_count_reg + 32'h1;
  end

  assign crc_counts = rx_crc_fault &&
    !(rx_collided && rx_frame_length < {6'h00, nis_pkg::runt_limit});

  // Early threshold fires once per packet, rearmed at its end
  always_ff @(posedge clk)
  begin
    if (reset)
      early_crossed_reg <= 1'b0;
    else if (clk_en)
    begin
      if (rx_packet_end)
        early_crossed_reg <= 1'b0;
      else if (rx_byte_count > early_threshold_reg)
        early_crossed_reg <= 1'b1;
    end
  end

  always_comb
  begin
    event_now = 16'h0000;
    event_now[nis_pkg::bit_system_error_event] = pin_rise[3];
    event_now[nis_pkg::bit_timeout] =
      free_running_timer_count_reg == timer_compare_value_reg;
    event_now[nis_pkg::bit_cable_length_change_event] =
      pin_rise[2] && control_reg[nis_pkg::ctl_rx_enable];
    event_now[nis_pkg::bit_rx_status_fifo_overflow_event] = pin_rise[1];
    event_now[nis_pkg::bit_pun] = (rx_read_pointer_write && rx_buffer_empty)
      || (link_sync != link_last_reg);
    event_now[nis_pkg::bit_rx_ring_overflow_event] = rx_ring_overflow_event;
    event_now[nis_pkg::bit_ter] = tx_abort_event;
    event_now[nis_pkg::bit_tok] = tx_done_event;
    event_now[nis_pkg::bit_rer] = rx_packet_end &&
      (crc_counts || frame_alignment_fault);
    if (control_reg[nis_pkg::ctl_early])
      event_now[nis_pkg::bit_rok] = !early_crossed_reg && !rx_packet_end &&
        rx_byte_count > early_threshold_reg;
    else
      event_now[nis_pkg::bit_rok] = rx_packet_end && rx_packet_good;
  end

  // AXI write channels taken in either order
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      s_axi_awready <= 1'b0;
    end
    else if (clk_en)
    begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else if (clk_en)
    begin
      s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (do_write)
        w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= nis_pkg::resp_okay;
    end
    else if (clk_en)
    begin
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr_reg[7:2])
          nis_pkg::status_offset[5:0], nis_pkg::mask_offset[5:0],
          nis_pkg::timer_offset[7:2], nis_pkg::compare_offset[7:2],
          nis_pkg::control_offset[7:2], nis_pkg::state_offset[7:2]:
            s_axi_bresp <= nis_pkg::resp_okay;
          default:
            s_axi_bresp <= nis_pkg::resp_slverr;
        endcase
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign write_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  always_ff @(posedge clk)
  begin
    if (reset)
      interrupt_enable_mask_reg <= nis_pkg::mask_reset;
    else if (clk_en && do_write &&
             aw_addr_reg[7:2] == nis_pkg::mask_offset[5:0])
      interrupt_enable_mask_reg <= (interrupt_enable_mask_reg & ~write_mask)
        | (w_data_reg[15:0] & write_mask & nis_pkg::event_bits);
  end

  // Config words; one register per lane is plenty here
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      timer_compare_value_reg <= nis_pkg::compare_reset;
      early_threshold_reg <= nis_pkg::threshold_reset;
      control_reg <= 2'h0;
    end
    else if (clk_en && do_write)
    begin
      if (aw_addr_reg[7:2] == nis_pkg::compare_offset[7:2])
        timer_compare_value_reg <= w_data_reg;
      if (aw_addr_reg[7:2] == nis_pkg::control_offset[7:2])
      begin
        control_reg <= w_data_reg[1:0];
        early_threshold_reg <= w_data_reg[31:16];
      end
    end
  end

  // Read channel, one outstanding read
  assign do_read = s_axi_arvalid && s_axi_arready;
  always_comb
  begin
    read_word = 32'h00000000;
    read_ok = 1'b1;
    unique case (s_axi_araddr[7:2])
      nis_pkg::status_offset[5:0]:
        read_word = {16'h0000, interrupt_event_status_reg};
      nis_pkg::mask_offset[5:0]:
        read_word = {16'h0000, interrupt_enable_mask_reg};
      nis_pkg::timer_offset[7:2]:
        read_word = free_running_timer_count_reg;
      nis_pkg::compare_offset[7:2]:
        read_word = timer_compare_value_reg;
      nis_pkg::control_offset[7:2]:
        read_word = {early_threshold_reg, 14'h0000, control_reg};
      nis_pkg::state_offset[7:2]:
        read_word = {27'h0000000, early_crossed_reg, pin_sync};
      default:
        read_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= nis_pkg::resp_okay;
    end
    else if (clk_en)
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (do_read)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_word;
        s_axi_rresp <= read_ok ? nis_pkg::resp_okay : nis_pkg::resp_slverr;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  always_comb
  begin
    interrupt_event_status_next = interrupt_event_status_reg;
    if (do_read && s_axi_araddr[7:2] == nis_pkg::status_offset[5:0])
      interrupt_event_status_next = 16'h0000;
    interrupt_event_status_next = (interrupt_event_status_next | event_now)
      & nis_pkg::event_bits;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      interrupt_event_status_reg <= nis_pkg::status_reset;
    else if (clk_en)
      interrupt_event_status_reg <= interrupt_event_status_next;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      interrupt_out <= 1'b0;
    else if (clk_en)
      interrupt_out <= |(interrupt_event_status_next &
                         interrupt_enable_mask_reg);
  end
endmodule

// File: nis_unit_assertions.sv
// Port-level assertions for the interrupt status unit
`timescale 1ns/100ps
module nis_unit_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic interrupt_out
);
  localparam logic [7:0] status_addr = {nis_pkg::status_offset[5:0], 2'h0};
  localparam logic [7:0] mask_addr = {nis_pkg::mask_offset[5:0], 2'h0};
  logic [7:0] rd_addr_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic [3:0] wr_strb_reg;
  logic [15:0] mask_reg;
  logic rd_known;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Ready only pulses after a valid, so it alone marks a transfer
  always_ff @(posedge clk)
  begin
    if (s_axi_arready) rd_addr_reg <= s_axi_araddr;
    if (s_axi_awready) wr_addr_reg <= s_axi_awaddr;
    if (s_axi_wready) wr_strb_reg <= s_axi_wstrb;
    if (s_axi_wready) wr_data_reg <= s_axi_wdata;
  end
  // Mask copy lags the real one, so it never claims zero too early
  always_ff @(posedge clk)
  begin
    if (reset)
      mask_reg <= 16'h0000;
    else if (s_axi_bvalid && s_axi_bready &&
      wr_addr_reg == mask_addr)
    begin
      if (wr_strb_reg[0]) mask_reg[7:0] <= wr_data_reg[7:0];
      if (wr_strb_reg[1]) mask_reg[15:8] <= wr_data_reg[15:8];
    end
  end
  assign rd_known = rd_addr_reg inside {status_addr, mask_addr,
    nis_pkg::timer_offset, nis_pkg::compare_offset,
    nis_pkg::control_offset, nis_pkg::state_offset};
  a_mask_gates: assert property (
    mask_reg == 16'h0000 && $past(mask_reg) == 16'h0000 |-> !interrupt_out)
    else $error("interrupt raised with mask clear");
  a_reserved_zero: assert property (
    s_axi_rvalid && rd_addr_reg == status_addr
    |-> s_axi_rdata[12:7] == 6'h00) else $error("reserved status bit set");
  a_unmapped_err: assert property (s_axi_rvalid && !rd_known
    |-> s_axi_rresp == nis_pkg::resp_slverr && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read address taken without answer");
  a_arready_pulse: assert property (s_axi_arvalid && !s_axi_arready &&
    !s_axi_rvalid |=> s_axi_arready ##1 !s_axi_arready)
    else $error("read address not taken in one cycle");
  a_write_answer: assert property (s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("write without response");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write response dropped");
  a_reset_quiet: assert property ($past(reset)
    |-> !interrupt_out && !s_axi_rvalid && !s_axi_bvalid)
    else $error("outputs active after reset");
endmodule

// File: nis_unit_tb_top.sv
// Self-checking bench for the interrupt status unit
`timescale 1ns/100ps
module nis_unit_tb_top;
  localparam logic [33:0] all_care = 34'h3ffffffff;
  localparam logic [7:0] status_addr = {nis_pkg::status_offset[5:0], 2'h0};
  localparam logic [7:0] mask_addr = {nis_pkg::mask_offset[5:0], 2'h0};
  logic clk = 1'h0, reset = 1'h1, go = 1'h0, rx_collided = 1'h0, col;
  logic clk_en = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [15:0] ev = 16'h0, rx_byte_count = 16'h0, draw, x, m;
  logic [10:0] rx_frame_length = 11'h0, len;
  logic [33:0] exp_q[$], care_q[$];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, interrupt_out;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire system_error_event, cable_length_change_event, rx_buffer_empty;
  wire rx_status_fifo_overflow_event, rx_read_pointer_write, link_status;
  wire rx_ring_overflow_event, tx_abort_event, tx_done_event;
  wire rx_packet_end, rx_packet_good, rx_crc_fault, frame_alignment_fault;
  int err_count = 0, n_compared = 0, cyc = 0, seed = 32'h2ce2;
  nis_unit i_nis_unit (.clk, .reset, .clk_en, .system_error_event,
    .cable_length_change_event, .rx_status_fifo_overflow_event,
    .rx_read_pointer_write, .rx_buffer_empty, .link_status,
    .rx_ring_overflow_event, .tx_abort_event, .tx_done_event,
    .rx_packet_end, .rx_packet_good, .rx_crc_fault, .frame_alignment_fault,
    .rx_collided, .rx_frame_length, .rx_byte_count, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .interrupt_out);
  nis_event_model i_nis_event_model (.clk, .go, .ev, .system_error_event,
    .cable_length_change_event, .rx_status_fifo_overflow_event,
    .rx_read_pointer_write, .rx_buffer_empty, .link_status,
    .rx_ring_overflow_event, .tx_abort_event, .tx_done_event,
    .rx_packet_end, .rx_packet_good, .rx_crc_fault, .frame_alignment_fault);
  always #10 clk = ~clk;
  task print_verdict();
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Roughly 1000 cycles are needed; anything far beyond is a hang
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end
  always @(posedge clk)
  begin
    if (s_axi_rvalid && s_axi_rready)
    begin
      n_compared++;
      if (({s_axi_rresp, s_axi_rdata} & care_q[0]) !== exp_q[0])
      begin
        err_count++;
        $display("BAD read: expected %h seen %h", exp_q[0],
          {s_axi_rresp, s_axi_rdata});
      end
      void'(exp_q.pop_front());
      void'(care_q.pop_front());
    end
  end
  task chk(input logic e);
    n_compared++;
    if (interrupt_out !== e)
    begin
      err_count++;
      $display("BAD interrupt_out: expected %h seen %h", e, interrupt_out);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    n_compared++;
    if (s_axi_bresp !== nis_pkg::resp_okay)
    begin
      err_count++;
      $display("BAD bresp: expected %h seen %h", nis_pkg::resp_okay,
        s_axi_bresp);
    end
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    care_q.push_back(all_care);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask
  task fire(input logic [15:0] e);
    @(posedge clk);
    ev <= e;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    repeat (8) @(posedge clk);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    rd(status_addr, 34'h000004000);
    rd(mask_addr, 34'h0);
    rd(nis_pkg::control_offset, 34'h0);
    rd(8'h80, {nis_pkg::resp_slverr, 32'h0});
    wr(nis_pkg::compare_offset, 32'hffffffff);
    rd(nis_pkg::compare_offset, 34'h0ffffffff);
    wr(nis_pkg::control_offset, 32'h00000002);
    repeat (24)
    begin
      draw = 16'($random(seed)) & 16'ha1ff;
      m = 16'($random(seed)) & nis_pkg::event_bits;
      col = 1'($random(seed));
      len = 11'($random(seed)) & 11'h01f;
      x = draw & nis_pkg::event_bits;
      if (draw[1] && !draw[7] && col && len < 11'h010) x[1] = 1'h0;
      if (draw[1]) x[0] = 1'h0;
      rx_collided <= col;
      rx_frame_length <= len;
      wr(mask_addr, {16'($random(seed)), m});
      fire(draw);
      @(posedge clk);
      chk(|(x & m));
      wr(status_addr, 32'($random(seed)));
      rd(mask_addr, {18'h0, m});
      rd(status_addr, {18'h0, x});
      repeat (3) @(posedge clk);
      chk(1'h0);
    end
    wr(nis_pkg::compare_offset, 32'(cyc + 30));
    repeat (60) @(posedge clk);
    rd(status_addr, 34'h000004000);
    // A frozen unit must miss a one-cycle transmit pulse
    clk_en <= 1'h0;
    fire(16'h0004);
    clk_en <= 1'h1;
    rd(status_addr, 34'h0);
    wr(nis_pkg::control_offset, 32'h0);
    fire(16'h2000);
    rd(status_addr, 34'h0);
    wr(nis_pkg::control_offset, 32'h00640003);
    rx_byte_count <= 16'h0064;
    repeat (8) @(posedge clk);
    rd(status_addr, 34'h0);
    rx_byte_count <= 16'h0065;
    repeat (8) @(posedge clk);
    rd(status_addr, 34'h000000001);
    print_verdict();
  end
endmodule
bind nis_unit nis_unit_assertions i_nis_unit_assertions (.clk, .reset,
  .s_axi_awready, .s_axi_awaddr, .s_axi_wdata, .s_axi_wstrb, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .interrupt_out);
